/* hw/ssf_defines.svh */
`ifndef SSF_DEFINES_SVH
`define SSF_DEFINES_SVH

// Register byte offsets
`define SSF_OFF_CTRL 12'h000
`define SSF_OFF_STATUS 12'h014
`define SSF_OFF_TX 12'h020
`define SSF_OFF_RX 12'h030
`define SSF_OFF_INTSTS 12'h040
`define SSF_OFF_INTEN 12'h044

// Control register fields
`define SSF_CTRL_EN 0
`define SSF_CTRL_MASTER 1
`define SSF_CTRL_RX_PATH_RESET 2
`define SSF_CTRL_TH_LSB 4
`define SSF_CTRL_TH_MSB 7

// Status register fields
`define SSF_ST_TX_QUEUE_EMPTY 16
`define SSF_ST_ENSTS 15
`define SSF_ST_RXTO 12
`define SSF_ST_RXOV 11
`define SSF_ST_RX_LEVEL_THRESHOLD 10
`define SSF_ST_RX_QUEUE_FULL 9
`define SSF_ST_RX_QUEUE_EMPTY 8
`define SSF_ST_SLVUR 7

// Interrupt status and mask fields
`define SSF_INT_TO 0
`define SSF_INT_OV 1
`define SSF_INT_UR 2
`define SSF_INT_W 3

// Data path sizes
`define SSF_WORD_BITS 8
`define SSF_FIFO_DEPTH 8
`define SSF_PTR_W 3
`define SSF_CNT_W 4
`define SSF_BIT_LAST 3'h7

// Receive time-out limits
`define SSF_TO_W 10
`define SSF_TO_MASTER_SCLK 10'h040
`define SSF_TO_SLAVE_PCLK 10'h240

// Serial clock generation in master mode
`define SSF_MCLK_PERIOD_NS 50
`define SSF_SCLK_PERIOD_NS 400
`define SSF_DIV_W 4
`define SSF_SCLK_HALF_CYC ((`SSF_SCLK_PERIOD_NS / 2) / `SSF_MCLK_PERIOD_NS)

`endif

/* hw/ssf_pkg.sv */
package ssf_pkg;
    // Serial shifter state
    typedef enum logic {
        SH_IDLE,
        SH_ACTIVE
    } ssf_shift_t;
endpackage : ssf_pkg

/* hw/ssf_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser, one chain per bit
module ssf_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk, // Sampling clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [WIDTH-1:0] async_in, // Inputs from outside the domain
    output logic [WIDTH-1:0] sync_out // Synchronised outputs
);
    logic [WIDTH-1:0] meta; // First stage, read only by second stage

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // Two flops per bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta[i] <= INIT[i];
                    sync_out[i] <= INIT[i];
                end else begin
                    meta[i] <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule : ssf_sync

/* hw/ssf_fifo.sv */
`timescale 1ns/1ps
`include "ssf_defines.svh"
// Word queue with flush, count and level flags
module ssf_fifo (
    input wire logic clk, // Clock
    input wire logic rst_n, // Async reset, active low
    input wire logic flush, // Pointer reset
    input wire logic push, // Write strobe, dropped when full
    input wire logic [`SSF_WORD_BITS-1:0] push_data, // Write data
    input wire logic pop, // Read strobe, ignored when empty
    output logic [`SSF_WORD_BITS-1:0] pop_data, // Head entry
    output logic [`SSF_CNT_W-1:0] count, // Entries held
    output logic full, // All entries used
    output logic empty // No entries
);
    logic [`SSF_WORD_BITS-1:0] mem [`SSF_FIFO_DEPTH]; // Storage
    logic [`SSF_PTR_W-1:0] wr_ptr; // Write pointer
    logic [`SSF_PTR_W-1:0] rd_ptr; // Read pointer
    logic do_push; // Accepted write
    logic do_pop; // Accepted read

    assign full = (count == `SSF_CNT_W'(`SSF_FIFO_DEPTH));
    assign empty = (count == '0);
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign pop_data = mem[rd_ptr];

    // Storage write
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : ssf_fifo

/* hw/ssf_status_top.sv */
`timescale 1ns/1ps
`include "ssf_defines.svh"
// Summary of operation
// - Transmit-empty bit mirrors empty transmit queue
// - Enable-state bit shows synchronised controller enable
// - Time-out flag when unread receive data idles
// - Reading receive data clears time-out condition
// - Writing one clears time-out flag
// - Full receive queue drops word, flags overrun
// - Level flag when count exceeds threshold
// - Receive-full bit while every entry used
// - Receive-empty bit while queue holds nothing
// - Underflow then select release sets underrun
// - Underflow means queue and shifter empty, selected
// - Underrun flag held until written one
// - Receive reset clears pointers, full, sets empty
module ssf_status_top (
    input wire logic MCLK, // System clock
    input wire logic NRST, // Async reset, active low
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction
    input wire logic [11:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB transfer done
    output logic PSLVERR, // APB unmapped address
    output logic IRQ, // Level interrupt
    input wire logic SCLK_IN, // Serial clock from master
    input wire logic SS_IN_N, // Slave select, active low
    input wire logic SDI, // Serial data in
    output logic SCLK_OUT, // Serial clock in master mode
    output logic SS_OUT_N, // Slave select out, active low
    output logic SDO // Serial data out
);
    // Address compare shared by read and write decode
    function automatic logic ssf_hit(input logic [11:0] addr, input logic [11:0] off);
        ssf_hit = (addr == off);
    endfunction : ssf_hit

    logic ctrl_en; // Software enable
    logic ctrl_master; // Master mode select
    logic [`SSF_CNT_W-1:0] rx_level_threshold; // Receive threshold
    logic rx_path_reset; // Receive reset pulse
    logic rx_timeout_flag; // Sticky time-out
    logic rx_overrun_flag; // Sticky overrun
    logic slave_tx_underrun_flag; // Sticky underrun
    logic [`SSF_INT_W-1:0] int_sts; // Interrupt status, read clears
    logic [`SSF_INT_W-1:0] int_en; // Interrupt mask
    logic s_sclk; // Synchronised serial clock
    logic s_ss_n; // Synchronised select
    logic s_sdi; // Synchronised data
    logic ctrl_enable_state; // Enable seen through crossing
    logic sclk_q; // Previous serial clock sample
    logic [`SSF_DIV_W-1:0] half_cnt; // Divider count
    logic phase; // Second half of serial period
    logic half_tick; // Half-period enable
    logic period_tick; // Full-period enable
    ssf_pkg::ssf_shift_t state; // Shifter state
    logic [2:0] bit_cnt; // Bit within word
    logic loaded; // Word loaded into shifter
    logic [`SSF_WORD_BITS-1:0] tx_sh; // Transmit shifter
    logic tx_sh_full; // Shifter holds queued data
    logic [`SSF_WORD_BITS-1:0] rx_sh; // Receive shifter
    logic underflow_seen; // Underflow during this select
    logic [`SSF_TO_W-1:0] to_cnt; // Time-out counter
    logic [`SSF_TO_W-1:0] to_limit; // Active time-out limit
    logic to_inc; // Time-out counter step
    logic rise; // Sample edge
    logic fall; // Shift edge
    logic slave_sel; // Selected as slave
    logic enter_active; // Word sequence begins
    logic tx_pop; // Load from transmit queue
    logic rx_push; // Completed receive word
    logic rx_pop; // Software read of receive data
    logic access; // First access cycle
    logic wr_done; // Write completes
    logic rd_done; // Read completes
    logic mapped; // Address decodes
    logic ev_timeout; // Time-out event
    logic ev_overrun; // Overrun event
    logic ev_underrun; // Underrun event
    logic underflow; // Underflow condition
    logic [31:0] next_prdata; // Read mux
    logic [`SSF_WORD_BITS-1:0] tx_head; // Transmit queue head
    logic [`SSF_WORD_BITS-1:0] rx_head; // Receive queue head
    logic [`SSF_CNT_W-1:0] tx_cnt; // Transmit entries
    logic [`SSF_CNT_W-1:0] rx_cnt; // Receive entries
    logic tx_full; // Transmit queue full
    logic tx_empty; // Transmit queue empty
    logic rx_full; // Receive queue full
    logic rx_empty; // Receive queue empty

    // Pin and enable crossings; select idles high
    ssf_sync #(.WIDTH(4), .INIT(4'h4)) u_sync (
        .clk(MCLK),
        .rst_n(NRST),
        .async_in({ctrl_en, SS_IN_N, SDI, SCLK_IN}),
        .sync_out({ctrl_enable_state, s_ss_n, s_sdi, s_sclk})
    );

    // Transmit queue, filled by software
    ssf_fifo u_tx_fifo (
        .clk(MCLK),
        .rst_n(NRST),
        .flush(1'b0),
        .push(wr_done && ssf_hit(PADDR, `SSF_OFF_TX)),
        .push_data(PWDATA[`SSF_WORD_BITS-1:0]),
        .pop(tx_pop),
        .pop_data(tx_head),
        .count(tx_cnt),
        .full(tx_full),
        .empty(tx_empty)
    );

    // Receive queue; reset path flushes pointers
    ssf_fifo u_rx_fifo (
        .clk(MCLK),
        .rst_n(NRST),
        .flush(rx_path_reset),
        .push(rx_push),
        .push_data({rx_sh[`SSF_WORD_BITS-2:0], s_sdi}),
        .pop(rx_pop),
        .pop_data(rx_head),
        .count(rx_cnt),
        .full(rx_full),
        .empty(rx_empty)
    );

    // Bus phase decode
    assign access = PSEL && PENABLE && !PREADY;
    assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
    assign rd_done = PSEL && PENABLE && PREADY && !PWRITE;
    assign mapped = ssf_hit(PADDR, `SSF_OFF_CTRL) || ssf_hit(PADDR, `SSF_OFF_STATUS)
        || ssf_hit(PADDR, `SSF_OFF_TX) || ssf_hit(PADDR, `SSF_OFF_RX)
        || ssf_hit(PADDR, `SSF_OFF_INTSTS) || ssf_hit(PADDR, `SSF_OFF_INTEN);
    assign rx_pop = rd_done && ssf_hit(PADDR, `SSF_OFF_RX);

    // Read mux; unnamed bits stay zero
    always_comb begin
        next_prdata = '0;
        if (ssf_hit(PADDR, `SSF_OFF_CTRL)) begin
            next_prdata[`SSF_CTRL_EN] = ctrl_en;
            next_prdata[`SSF_CTRL_MASTER] = ctrl_master;
            next_prdata[`SSF_CTRL_TH_MSB:`SSF_CTRL_TH_LSB] = rx_level_threshold;
        end else if (ssf_hit(PADDR, `SSF_OFF_STATUS)) begin
            next_prdata[`SSF_ST_TX_QUEUE_EMPTY] = tx_empty;
            next_prdata[`SSF_ST_ENSTS] = ctrl_enable_state;
            next_prdata[`SSF_ST_RXTO] = rx_timeout_flag;
            next_prdata[`SSF_ST_RXOV] = rx_overrun_flag;
            next_prdata[`SSF_ST_RX_LEVEL_THRESHOLD] = (rx_cnt > rx_level_threshold);
            next_prdata[`SSF_ST_RX_QUEUE_FULL] = rx_full;
            next_prdata[`SSF_ST_RX_QUEUE_EMPTY] = rx_empty;
            next_prdata[`SSF_ST_SLVUR] = slave_tx_underrun_flag;
        end else if (ssf_hit(PADDR, `SSF_OFF_RX)) begin
            next_prdata[`SSF_WORD_BITS-1:0] = rx_head;
        end else if (ssf_hit(PADDR, `SSF_OFF_INTSTS)) begin
            next_prdata[`SSF_INT_W-1:0] = int_sts;
        end else if (ssf_hit(PADDR, `SSF_OFF_INTEN)) begin
            next_prdata[`SSF_INT_W-1:0] = int_en;
        end
    end

    // Bus answer, one wait state
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            PREADY <= 1'b0;
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= access;
            PSLVERR <= access && !mapped;
            if (access && !PWRITE) begin
                PRDATA <= next_prdata;
            end
        end
    end

    // Control register and self-clearing receive reset
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_en <= 1'b0;
            ctrl_master <= 1'b0;
            rx_level_threshold <= '0;
            rx_path_reset <= 1'b0;
            int_en <= '0;
        end else begin
            rx_path_reset <= 1'b0;
            if (wr_done && ssf_hit(PADDR, `SSF_OFF_CTRL)) begin
                ctrl_en <= PWDATA[`SSF_CTRL_EN];
                ctrl_master <= PWDATA[`SSF_CTRL_MASTER];
                rx_level_threshold <= PWDATA[`SSF_CTRL_TH_MSB:`SSF_CTRL_TH_LSB];
                rx_path_reset <= PWDATA[`SSF_CTRL_RX_PATH_RESET];
            end
            if (wr_done && ssf_hit(PADDR, `SSF_OFF_INTEN)) begin
                int_en <= PWDATA[`SSF_INT_W-1:0];
            end
        end
    end

    // Serial clock divider, free running
    assign half_tick = (half_cnt == `SSF_DIV_W'(`SSF_SCLK_HALF_CYC - 1));
    assign period_tick = half_tick && phase;
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            half_cnt <= '0;
            phase <= 1'b0;
        end else if (half_tick) begin
            half_cnt <= '0;
            phase <= !phase;
        end else begin
            half_cnt <= half_cnt + 1'b1;
        end
    end

    // Edge selection by mode
    assign slave_sel = ctrl_en && !ctrl_master && !s_ss_n;
    assign rise = (state == ssf_pkg::SH_ACTIVE) && (ctrl_master ? (half_tick && !SCLK_OUT)
        : (s_sclk && !sclk_q));
    assign fall = (state == ssf_pkg::SH_ACTIVE) && (ctrl_master ? (half_tick && SCLK_OUT)
        : (!s_sclk && sclk_q));
    assign enter_active = (state == ssf_pkg::SH_IDLE)
        && (ctrl_master ? (ctrl_en && !tx_empty) : slave_sel);
    assign tx_pop = !tx_empty && (enter_active || (fall && (bit_cnt == '0) && !loaded));
    assign rx_push = rise && (bit_cnt == `SSF_BIT_LAST);

    // Shifter sequencing
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state <= ssf_pkg::SH_IDLE;
            sclk_q <= 1'b0;
            bit_cnt <= '0;
            loaded <= 1'b0;
            tx_sh <= '0;
            tx_sh_full <= 1'b0;
            rx_sh <= '0;
            SCLK_OUT <= 1'b0;
            SS_OUT_N <= 1'b1;
        end else begin
            sclk_q <= s_sclk;
            case (state)
                ssf_pkg::SH_IDLE: begin
                    bit_cnt <= '0;
                    if (enter_active) begin
                        // Start of a select period
                        state <= ssf_pkg::SH_ACTIVE;
                        loaded <= 1'b1;
                        tx_sh <= tx_empty ? '0 : tx_head;
                        tx_sh_full <= !tx_empty;
                        SS_OUT_N <= !ctrl_master;
                    end
                end
                ssf_pkg::SH_ACTIVE: begin
                    if (!ctrl_en || (!ctrl_master && s_ss_n)
                        || (ctrl_master && fall && (bit_cnt == '0) && !loaded && tx_empty)) begin
                        // Disabled, select released or queue drained
                        state <= ssf_pkg::SH_IDLE;
                        loaded <= 1'b0;
                        tx_sh_full <= 1'b0;
                        SCLK_OUT <= 1'b0;
                        SS_OUT_N <= 1'b1;
                    end else begin
                        if (ctrl_master && half_tick) begin
                            SCLK_OUT <= !SCLK_OUT;
                        end
                        if (rise) begin
                            // Sample data, count bit
                            rx_sh <= {rx_sh[`SSF_WORD_BITS-2:0], s_sdi};
                            bit_cnt <= bit_cnt + 1'b1;
                            if (bit_cnt == `SSF_BIT_LAST) begin
                                loaded <= 1'b0;
                                tx_sh_full <= 1'b0;
                            end
                        end else if (fall) begin
                            if ((bit_cnt == '0) && !loaded) begin
                                // Next word, zeros on empty queue
                                loaded <= 1'b1;
                                tx_sh <= tx_empty ? '0 : tx_head;
                                tx_sh_full <= !tx_empty;
                            end else begin
                                tx_sh <= {tx_sh[`SSF_WORD_BITS-2:0], 1'b0};
                            end
                        end
                    end
                end
                default: begin
                    state <= ssf_pkg::SH_IDLE;
                end
            endcase
        end
    end
    assign SDO = tx_sh[`SSF_WORD_BITS-1];

    assign underflow = slave_sel && tx_empty && !tx_sh_full;

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            underflow_seen <= 1'b0;
        end else if (s_ss_n || ctrl_master) begin
            underflow_seen <= 1'b0;
        end else if (underflow) begin
            underflow_seen <= 1'b1;
        end
    end
    assign ev_underrun = underflow_seen && s_ss_n && !ctrl_master;

    assign to_limit = ctrl_master ? `SSF_TO_MASTER_SCLK : `SSF_TO_SLAVE_PCLK;
    assign to_inc = !rx_empty && (ctrl_master ? period_tick : 1'b1) && (to_cnt <= to_limit);
    assign ev_timeout = to_inc && (to_cnt == to_limit);
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            to_cnt <= '0;
        end else if (rx_empty || rx_pop || rx_path_reset) begin
            to_cnt <= '0;
        end else if (to_inc) begin
            to_cnt <= to_cnt + 1'b1;
        end
    end

    // push into full queue is dropped
    assign ev_overrun = rx_push && rx_full;

    // Sticky status flags, set beats clear
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rx_timeout_flag <= 1'b0;
            rx_overrun_flag <= 1'b0;
            slave_tx_underrun_flag <= 1'b0;
        end else begin
            if (ev_timeout) begin
                rx_timeout_flag <= 1'b1;
            end else if (rx_pop || (wr_done && ssf_hit(PADDR, `SSF_OFF_STATUS)
                && PWDATA[`SSF_ST_RXTO])) begin
                rx_timeout_flag <= 1'b0;
            end
            if (ev_overrun) begin
                rx_overrun_flag <= 1'b1;
            end else if (wr_done && ssf_hit(PADDR, `SSF_OFF_STATUS) && PWDATA[`SSF_ST_RXOV]) begin
                rx_overrun_flag <= 1'b0;
            end
            if (ev_underrun) begin
                slave_tx_underrun_flag <= 1'b1;
            end else if (wr_done && ssf_hit(PADDR, `SSF_OFF_STATUS) && PWDATA[`SSF_ST_SLVUR]) begin
                slave_tx_underrun_flag <= 1'b0;
            end
        end
    end

    // Interrupt status, cleared by read, set wins
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            int_sts <= '0;
            IRQ <= 1'b0;
        end else begin
            int_sts <= ((rd_done && ssf_hit(PADDR, `SSF_OFF_INTSTS)) ? '0 : int_sts)
                | {ev_underrun, ev_overrun, ev_timeout};
            IRQ <= |(int_sts & int_en);
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    AST_TX_QUEUE_EMPTY_READ: assert property (
        (access && !PWRITE && ssf_hit(PADDR, `SSF_OFF_STATUS))
        |=> PRDATA[`SSF_ST_TX_QUEUE_EMPTY] == $past(tx_cnt == '0))
        else $error("transmit empty bit wrong");
    AST_ENSTS_LAG: assert property (
        $rose(ctrl_en) ##1 ctrl_en |-> ##1 ctrl_enable_state)
        else $error("enable state not reported");
    AST_TO_SET: assert property (
        $rose(rx_timeout_flag) |-> $past(to_cnt) == $past(to_limit) && !$past(rx_empty))
        else $error("time-out set at wrong count");
    AST_TO_READ_CLR: assert property (
        (rx_pop && !ev_timeout) |=> !rx_timeout_flag && to_cnt == '0)
        else $error("read did not clear time-out");
    AST_TO_W1C: assert property (
        (wr_done && ssf_hit(PADDR, `SSF_OFF_STATUS) && !PWDATA[`SSF_ST_RXTO]
        && rx_timeout_flag) |=> rx_timeout_flag)
        else $error("write zero changed time-out");
    AST_OVERRUN: assert property (
        (rx_push && rx_full && !rx_pop && !rx_path_reset)
        |=> rx_overrun_flag && rx_cnt == `SSF_CNT_W'(`SSF_FIFO_DEPTH))
        else $error("overrun not flagged");
    AST_LEVEL_READ: assert property (
        (access && !PWRITE && ssf_hit(PADDR, `SSF_OFF_STATUS))
        |=> PRDATA[`SSF_ST_RX_LEVEL_THRESHOLD] == $past(rx_cnt > rx_level_threshold))
        else $error("level flag wrong");
    AST_FULL_COUNT: assert property (
        rx_full == (rx_cnt == `SSF_CNT_W'(`SSF_FIFO_DEPTH)))
        else $error("full bit disagrees with count");
    AST_UNDERRUN_SET: assert property (
        (underflow_seen && $rose(s_ss_n) && !ctrl_master) |=> slave_tx_underrun_flag)
        else $error("underrun not flagged");
    AST_UNDERRUN_HOLD: assert property (
        slave_tx_underrun_flag && !(wr_done && PWDATA[`SSF_ST_SLVUR])
        |=> slave_tx_underrun_flag)
        else $error("underrun lost without write");
    AST_RX_RESET: assert property (
        rx_path_reset |=> rx_empty && !rx_full && rx_cnt == '0)
        else $error("receive reset incomplete");

    COV_TIMEOUT: cover property ($rose(rx_timeout_flag));
    COV_OVERRUN: cover property (ev_overrun);
    COV_UNDERRUN: cover property (ev_underrun);
    COV_MASTER_WORD: cover property (rx_push && ctrl_master);
endmodule : ssf_status_top

/* verification/ssf_peer.sv */
`timescale 1ns/1ps
// Serial master that sends words to the slave under test
module ssf_peer (
    output logic sclk, // Serial clock, still outside frames
    output logic ss_n, // Select, active low
    output logic sdi // Serial data to the slave
);
    // Idle link at time zero
    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        sdi = 1'b0;
    end
    // One frame of nw words from b0 upward, mode 0, MSB first
    task frame(input int nw, input logic [7:0] b0);
        logic [7:0] w;
        ss_n = 1'b0;
        #350;
        for (int i = 0; i < nw; i++) begin
            w = b0 + i[7:0];
            for (int k = 7; k >= 0; k--) begin
                sdi = w[k];
                #200 sclk = 1'b1;
                #200 sclk = 1'b0;
            end
        end
        #350 ss_n = 1'b1;
        // Released data line shows no stale bit
        sdi = ~sdi;
    endtask : frame
endmodule : ssf_peer

/* verification/spi_fifo_status_flags_tb_top.sv */
`timescale 1ns/1ps
`include "ssf_defines.svh"
module spi_fifo_status_flags_tb_top;
    logic MCLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, SCLK_IN, SS_IN_N, SDI;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, r;
    logic perr;
    int fails = 0;
    int tests_run = 0;
    // Clock at 50 ns
    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end
    ssf_status_top u_dut (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .IRQ(IRQ), .SCLK_IN(SCLK_IN), .SS_IN_N(SS_IN_N), .SDI(SDI),
        .SCLK_OUT(), .SS_OUT_N(), .SDO());
    ssf_peer u_peer (.sclk(SCLK_IN), .ss_n(SS_IN_N), .sdi(SDI));
    // Verdict and end of run
    task give_verdict;
        if (fails == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    // Compare seen against expected
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // One APB transfer, held until PREADY
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge MCLK);
        PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d; PENABLE <= 1'b0;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        r = PRDATA;
        perr = PSLVERR;
        PSEL <= 1'b0; PENABLE <= 1'b0;
        if (n >= 20) begin
            fails++;
            give_verdict();
        end
    endtask : xfer
    // Main sequence
    initial begin
        NRST = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = '0; PWDATA = '0;
        repeat (4) @(posedge MCLK);
        NRST <= 1'b1;
        xfer(0, `SSF_OFF_STATUS, 0); chk(r, 32'h0001_0100);
        xfer(1, `SSF_OFF_INTEN, 32'h0000_0007);
        xfer(1, `SSF_OFF_CTRL, 32'h0000_0011);
        xfer(0, `SSF_OFF_STATUS, 0); chk(r, 32'h0001_8100);
        // Nine words into an eight-deep queue, no transmit data
        u_peer.frame(9, 8'hA0);
        // Let the select release cross the synchroniser first
        repeat (4) @(posedge MCLK);
        xfer(0, `SSF_OFF_STATUS, 0); chk(r, 32'h0001_8E80);
        chk({31'h0, IRQ}, 32'h1);
        xfer(0, `SSF_OFF_INTSTS, 0); chk(r, 32'h0000_0006);
        repeat (2) @(posedge MCLK);
        chk({31'h0, IRQ}, 32'h0);
        xfer(1, `SSF_OFF_STATUS, 32'h0000_0880);
        xfer(0, `SSF_OFF_STATUS, 0); chk(r, 32'h0001_8600);
        repeat (600) @(posedge MCLK);
        xfer(0, `SSF_OFF_STATUS, 0); chk(r, 32'h0001_9600);
        xfer(1, `SSF_OFF_STATUS, 32'h0000_0000);
        xfer(0, `SSF_OFF_STATUS, 0); chk(r, 32'h0001_9600);
        xfer(1, `SSF_OFF_STATUS, 32'h0000_1000);
        xfer(0, `SSF_OFF_STATUS, 0); chk(r, 32'h0001_8600);
        repeat (600) @(posedge MCLK);
        // Drain; first pop also ends the idle time-out
        for (int i = 0; i < 8; i++) begin
            xfer(0, `SSF_OFF_RX, 0); chk(r[7:0], 8'hA0 + i[7:0]);
            xfer(0, `SSF_OFF_STATUS, 0);
            // Level flag only while more than one entry is left
            chk(r, i < 6 ? 32'h0001_8400 : (i < 7 ? 32'h0001_8000 : 32'h0001_8100));
        end
        u_peer.frame(1, 8'h3C);
        repeat (4) @(posedge MCLK);
        xfer(0, `SSF_OFF_STATUS, 0); chk(r, 32'h0001_8080);
        xfer(1, `SSF_OFF_CTRL, 32'h0000_0015);
        xfer(0, `SSF_OFF_STATUS, 0); chk(r, 32'h0001_8180);
        xfer(1, `SSF_OFF_TX, 32'h0000_0055);
        xfer(0, `SSF_OFF_STATUS, 0); chk(r, 32'h0000_8180);
        // Master mode: one word out, idle data line reads back ones, then idle time-out
        xfer(1, `SSF_OFF_CTRL, 32'h0000_0013);
        repeat (700) @(posedge MCLK);
        xfer(0, `SSF_OFF_STATUS, 0); chk(r, 32'h0001_9080);
        xfer(0, `SSF_OFF_RX, 0); chk(r[7:0], 8'hFF);
        // Unmapped address is refused
        xfer(0, 12'hFFC, 0); chk({perr, r[30:0]}, 32'h8000_0000);
        give_verdict();
    end
endmodule : spi_fifo_status_flags_tb_top
